// ===== rtl/scic_pkg.sv
`default_nettype none
package scic_pkg;
  // widths of the architectural state
  localparam int PC_W   = 24;
  localparam int SP_W   = 32;
  localparam int XP_W   = 40;
  localparam int NUM_XP = 8;
  localparam int NUM_SRC = 11;

  // apb register byte offsets
  localparam logic [11:0] OFF_CMD    = 12'h000;
  localparam logic [11:0] OFF_PC     = 12'h004;
  localparam logic [11:0] OFF_SP     = 12'h008;
  localparam logic [11:0] OFF_FLAGS  = 12'h00C;
  localparam logic [11:0] OFF_IE     = 12'h010;
  localparam logic [11:0] OFF_IF     = 12'h014;
  localparam logic [11:0] OFF_TARGET = 12'h018;
  localparam logic [11:0] OFF_XP     = 12'h040;
  localparam logic [11:0] OFF_XP_END = 12'h07C;

  // command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_COND_BIT = 4;
  localparam int CMD_ALW_BIT  = 5;
  localparam int CMD_ARG_LSB  = 8;

  // status word and flag register layout
  localparam int GIE_BIT  = 13;
  localparam int IRQ0_BIT = 0;
  localparam int IRQ1_BIT = 6;

  // vector table layout, word addresses from zero
  localparam logic [SP_W-1:0] VEC_RESET = 32'h0000_0000;
  localparam logic [SP_W-1:0] VEC_TRAP0 = 32'h0000_0020;

  // reset values
  localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
  localparam logic [31:0] RST_IE    = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_NONE, OP_CALL, OP_RET, OP_RETI, OP_TRAP,
    OP_PUSH, OP_STACK_STORE_HIGH, OP_POP, OP_STACK_LOAD_HIGH, OP_IRQ
  } scic_op_t;

  // flag bit to vector slot: external_irq_zero, int2, int3, xmt0, rcv0, xmt1, int1, rcv1, tim0, tim1, dma
  function automatic logic [SP_W-1:0] scic_vec_of(input logic [3:0] bit_idx);
    unique case (bit_idx)
      4'h0: scic_vec_of = 32'h0000_0001;
      4'h1: scic_vec_of = 32'h0000_0003;
      4'h2: scic_vec_of = 32'h0000_0004;
      4'h3: scic_vec_of = 32'h0000_0005;
      4'h4: scic_vec_of = 32'h0000_0006;
      4'h5: scic_vec_of = 32'h0000_0007;
      4'h6: scic_vec_of = 32'h0000_0002;
      4'h7: scic_vec_of = 32'h0000_0008;
      4'h8: scic_vec_of = 32'h0000_0009;
      4'h9: scic_vec_of = 32'h0000_000A;
      default: scic_vec_of = 32'h0000_000B;
    endcase
  endfunction
endpackage : scic_pkg
`default_nettype wire

// ===== rtl/scic_irq_if.sv
`default_nettype none
interface scic_irq_if #(parameter int NSRC = 11);
  localparam int IW = $clog2(NSRC);
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] enables;
  logic [NSRC-1:0] sw_data;
  logic            sw_wr;
  logic            ack;
  logic [IW-1:0]   ack_idx;
  logic            pend;
  logic [IW-1:0]   pend_idx;

  modport core  (output enables, sw_data, sw_wr, ack, ack_idx, input flags, pend, pend_idx);
  modport latch (input enables, sw_data, sw_wr, ack, ack_idx, output flags, pend, pend_idx);
endinterface : scic_irq_if
`default_nettype wire

// ===== rtl/scic_flag_unit.sv
`default_nettype none
module scic_flag_unit
  import scic_pkg::*;
#(
  parameter int NSRC = NUM_SRC
)(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [NSRC-1:0] evt_i,
  scic_irq_if.latch            irq
);
  localparam int IW = $clog2(NSRC);

  logic [NSRC-1:0] flag_ff;
  logic [NSRC-1:0] ready_w;

  assign irq.flags = flag_ff;
  assign ready_w   = flag_ff & irq.enables;

  // one latch per source; an arriving event beats any clear in the same cycle
  for (genvar i = 0; i < NSRC; i++) begin : g_flag
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        flag_ff[i] <= 1'b0;
      else if (evt_i[i])
        flag_ff[i] <= 1'b1; // latched whatever the enables say [RULE11] [RULE14]
      else if (irq.sw_wr)
        flag_ff[i] <= irq.sw_data[i]; // software may raise or discard [RULE13]
      else if (irq.ack && irq.ack_idx == IW'(i))
        flag_ff[i] <= 1'b0; // accepted source is not taken twice [RULE22]
    end
  end

  // lowest ready index wins, so source zero is most urgent
  always_comb
  begin
    irq.pend     = |ready_w; // flag and enable both needed [RULE12]
    irq.pend_idx = '0;
    for (int k = NSRC - 1; k >= 0; k--)
    begin
      if (ready_w[k])
        irq.pend_idx = IW'(k); // fixed order [RULE16] [RULE23]
    end
  end
endmodule : scic_flag_unit
`default_nettype wire

// ===== rtl/scic_ctrl.sv
// Contract
// RULE1: 24-bit program counter; a call bumps the stack pointer and stores the return address.
// RULE2: conditional return reloads the program counter from stack top when condition holds.
// RULE3: system stack grows toward higher addresses, holding calls, traps and interrupts.
// RULE4: 32-bit stack pointer always addresses the most recently pushed word.
// RULE5: push increments then writes; pop reads then decrements.
// RULE6: software reads and writes the stack pointer to switch between stacks.
// RULE7: reset leaves the stack pointer alone; software must load it first.
// RULE8: program counter pushed on call, trap, interrupt and popped on every return.
// RULE9: integer push stores low 32 bits, high push stores upper 32 bits.
// RULE10: high pop zeroes the lowest eight bits, so it must precede the integer pop.
// RULE11: any event sets its flag bit regardless of its enable.
// RULE12: service needs flag set, enable bit set and global enable equal to one.
// RULE13: software writes to the flag register raise or discard interrupts.
// RULE14: flags stay readable and keep latching while interrupts are masked.
// RULE15: acceptance pushes the program counter, loads the vector, clears global enable.
// RULE16: simultaneous pending interrupts are serviced one at a time in fixed order.
// RULE17: conditional interrupt return pops the program counter and sets global enable.
// RULE18: external interrupt one flag sits at mask 40H of the flag register.
// RULE19: global enable sits at mask 2000h of the status word; OR sets it.
// RULE20: enable bit 0 alone enables only external interrupt zero.
// RULE21: vector table from zero: reset, externals, serial, timers, dma, reserved, traps.
// RULE22: accepting an interrupt clears its flag bit.
// RULE23: lowest flag index wins; reset and external interrupt zero rank highest.
//
// Our own choices: the APB slave port and the address map.
`default_nettype none
module scic_ctrl
  import scic_pkg::*;
#(
  parameter int NSRC = NUM_SRC,
  parameter int AW   = 12
)(
  input  wire logic            CLK_I,
  input  wire logic            RST_I,
  input  wire logic            PSEL_I,
  input  wire logic            PENABLE_I,
  input  wire logic            PWRITE_I,
  input  wire logic [AW-1:0]   PADDR_I,
  input  wire logic [31:0]     PWDATA_I,
  output var  logic [31:0]     PRDATA_O,
  output logic                 PREADY_O,
  output logic                 PSLVERR_O,
  input  wire logic [NSRC-1:0] IRQ_EVT_I,
  output logic                 MEM_REQ_O,
  output logic                 MEM_WE_O,
  output var  logic [SP_W-1:0] MEM_ADDR_O,
  output var  logic [31:0]     MEM_WDATA_O,
  input  wire logic [31:0]     MEM_RDATA_I,
  input  wire logic            MEM_ACK_I,
  output var  logic [PC_W-1:0] PC_O,
  output logic                 GIE_O,
  output logic                 BUSY_O
);
  localparam int IW = $clog2(NSRC);

  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP, ST_VEC} scic_state_t;

  scic_state_t     state_ff;
  scic_op_t        op_ff;
  logic [2:0]      arg_ff;
  logic [PC_W-1:0] program_counter_ff;
  logic [SP_W-1:0] stack_pointer_ff;
  logic [31:0]     cpu_flags_word_ff;
  logic [NSRC-1:0] interrupt_enable_reg_ff;
  logic [PC_W-1:0] target_ff;
  logic [SP_W-1:0] mem_addr_ff;
  logic [31:0]     mem_wdata_ff;
  logic [31:0]     prdata_ff;
  logic            skipped_ff;
  logic [IW-1:0]   src_ff;
  logic [XP_W-1:0] ext_precision_regs_ff [NUM_XP];

  scic_irq_if #(.NSRC(NSRC)) irq ();

  scic_flag_unit #(.NSRC(NSRC)) u_flags (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .evt_i (IRQ_EVT_I),
    .irq   (irq)
  );

  // apb decode
  wire logic        apb_setup  = PSEL_I & ~PENABLE_I;
  wire logic        apb_access = PSEL_I & PENABLE_I;
  wire logic        apb_wr     = apb_access & PWRITE_I;
  wire logic [11:0] addr12     = 12'(PADDR_I);
  wire logic        hit_cmd    = addr12 == OFF_CMD;
  wire logic        hit_pc     = addr12 == OFF_PC;
  wire logic        hit_sp     = addr12 == OFF_SP;
  wire logic        hit_flags  = addr12 == OFF_FLAGS;
  wire logic        hit_ie     = addr12 == OFF_IE;
  wire logic        hit_if     = addr12 == OFF_IF;
  wire logic        hit_tgt    = addr12 == OFF_TARGET;
  wire logic        hit_xp     = addr12 >= OFF_XP && addr12 <= OFF_XP_END && addr12[1:0] == 2'b00;
  wire logic [2:0]  xp_idx     = addr12[5:3];
  wire logic        xp_hi      = addr12[2];
  wire logic        hit_any    = hit_cmd | hit_pc | hit_sp | hit_flags | hit_ie | hit_if | hit_tgt | hit_xp;
  wire logic        busy       = state_ff != ST_IDLE;
  // state that the sequencer owns may not be written under it
  wire logic        wr_locked  = busy & (hit_cmd | hit_pc | hit_sp | hit_flags | hit_xp);
  wire logic        wr_ok      = apb_wr & hit_any & ~wr_locked;

  assign PREADY_O  = apb_access; // zero wait states
  assign PSLVERR_O = apb_access & (~hit_any | (PWRITE_I & wr_locked));

  // command decode
  wire scic_op_t    cmd_op   = scic_op_t'(PWDATA_I[CMD_OP_LSB +: 4]);
  wire logic        cmd_take = PWDATA_I[CMD_ALW_BIT] | PWDATA_I[CMD_COND_BIT];
  wire logic [2:0]  cmd_arg  = PWDATA_I[CMD_ARG_LSB +: 3];
  wire logic        cmd_go   = wr_ok & hit_cmd;
  wire logic        cmd_cond = cmd_op == OP_CALL || cmd_op == OP_RET || cmd_op == OP_RETI;
  wire logic        cmd_skip = cmd_go & cmd_cond & ~cmd_take;
  wire logic        cmd_run  = cmd_go & ~cmd_skip & cmd_op != OP_NONE & cmd_op != OP_IRQ;
  wire logic        cmd_push = cmd_op == OP_CALL || cmd_op == OP_TRAP || cmd_op == OP_PUSH || cmd_op == OP_STACK_STORE_HIGH;

  // interrupt acceptance waits for an idle sequencer and no apb write access
  wire logic        global_int_enable      = cpu_flags_word_ff[GIE_BIT]; // mask 2000h [RULE19]
  wire logic        accept   = ~busy & ~apb_wr & global_int_enable & irq.pend; // all three gates [RULE12]

  assign irq.enables = interrupt_enable_reg_ff; // bit 0 alone covers only source zero [RULE20]
  assign irq.sw_wr   = wr_ok & hit_if;
  assign irq.sw_data = PWDATA_I[NSRC-1:0]; // external interrupt one lands on bit 6, mask 40H [RULE18]
  assign irq.ack     = accept;
  assign irq.ack_idx = irq.pend_idx;

  // words pushed for each kind of command push
  wire logic [PC_W-1:0] ret_addr = program_counter_ff + PC_W'(1);
  wire logic [XP_W-1:0] xp_sel   = ext_precision_regs_ff[cmd_arg];
  logic [31:0] push_word;
  always_comb
  begin
    unique case (cmd_op)
      OP_PUSH:  push_word = xp_sel[31:0]; // low 32 bits as integer [RULE9]
      OP_STACK_STORE_HIGH: push_word = xp_sel[XP_W-1:XP_W-32]; // upper 32 bits as float [RULE9]
      default:  push_word = {{(32 - PC_W){1'b0}}, ret_addr}; // following instruction [RULE1]
    endcase
  end

  // apb read mux, sampled in the setup cycle
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_cmd)
      rd_mux = {30'h0000_0000, skipped_ff, busy};
    else if (hit_pc)
      rd_mux = {{(32 - PC_W){1'b0}}, program_counter_ff};
    else if (hit_sp)
      rd_mux = stack_pointer_ff; // readable for stack switching [RULE6]
    else if (hit_flags)
      rd_mux = cpu_flags_word_ff;
    else if (hit_ie)
      rd_mux = 32'(interrupt_enable_reg_ff);
    else if (hit_if)
      rd_mux = 32'(irq.flags); // pollable while masked [RULE14]
    else if (hit_tgt)
      rd_mux = {{(32 - PC_W){1'b0}}, target_ff};
    else if (hit_xp)
      rd_mux = xp_hi ? {24'h00_0000, ext_precision_regs_ff[xp_idx][XP_W-1:32]}
                     : ext_precision_regs_ff[xp_idx][31:0];
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      prdata_ff <= 32'h0000_0000;
    else if (apb_setup)
      prdata_ff <= rd_mux;
  end

  // sequencer; reset starts by fetching the reset vector at word zero
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state_ff     <= ST_VEC;
      op_ff        <= OP_NONE;
      arg_ff       <= 3'h0;
      mem_addr_ff  <= VEC_RESET; // first slot of the table [RULE21]
      mem_wdata_ff <= 32'h0000_0000;
      skipped_ff   <= 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (accept)
          begin
            state_ff     <= ST_PUSH;
            op_ff        <= OP_IRQ;
            mem_addr_ff  <= stack_pointer_ff + 32'h0000_0001; // pre-increment [RULE5]
            mem_wdata_ff <= {{(32 - PC_W){1'b0}}, program_counter_ff}; // resume point [RULE15]
          end
          else if (cmd_go)
          begin
            skipped_ff <= cmd_skip;
            op_ff      <= cmd_op;
            arg_ff     <= cmd_arg;
            if (cmd_run && cmd_push)
            begin
              state_ff     <= ST_PUSH;
              mem_addr_ff  <= stack_pointer_ff + 32'h0000_0001; // grows upward [RULE3] [RULE5]
              mem_wdata_ff <= push_word;
            end
            else if (cmd_run)
            begin
              state_ff    <= ST_POP;
              mem_addr_ff <= stack_pointer_ff; // read the top first [RULE5]
            end
          end
        end
        ST_PUSH:
        begin
          if (MEM_ACK_I && (op_ff == OP_TRAP || op_ff == OP_IRQ))
          begin
            state_ff    <= ST_VEC;
            mem_addr_ff <= (op_ff == OP_TRAP) ? VEC_TRAP0 + 32'(arg_ff) : scic_vec_of(4'(src_ff));
          end
          else if (MEM_ACK_I)
            state_ff <= ST_IDLE;
        end
        ST_POP:
        begin
          if (MEM_ACK_I)
            state_ff <= ST_IDLE;
        end
        ST_VEC:
        begin
          if (MEM_ACK_I)
            state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // accepted source index, held for the vector fetch after the push
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      src_ff <= '0;
    else if (accept)
      src_ff <= irq.pend_idx;
  end

  // stack pointer carries no reset on purpose; software loads it before use [RULE7]
  always_ff @(posedge CLK_I)
  begin
    if (~busy && !accept && wr_ok && hit_sp)
      stack_pointer_ff <= PWDATA_I; // reload selects another stack [RULE6]
    else if (accept || (state_ff == ST_IDLE && cmd_run && cmd_push))
      stack_pointer_ff <= stack_pointer_ff + 32'h0000_0001; // always names the newest word [RULE4]
    else if (state_ff == ST_POP && MEM_ACK_I)
      stack_pointer_ff <= stack_pointer_ff - 32'h0000_0001; // post-decrement [RULE5]
  end

  // program counter updates
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      program_counter_ff <= '0;
    else if (state_ff == ST_VEC && MEM_ACK_I)
      program_counter_ff <= MEM_RDATA_I[PC_W-1:0]; // vector loaded [RULE15] [RULE21]
    else if (state_ff == ST_PUSH && MEM_ACK_I && op_ff == OP_CALL)
      program_counter_ff <= target_ff; // return address saved, jump [RULE1] [RULE8]
    else if (state_ff == ST_POP && MEM_ACK_I && (op_ff == OP_RET || op_ff == OP_RETI))
      program_counter_ff <= MEM_RDATA_I[PC_W-1:0]; // restored from top [RULE2] [RULE8]
    else if (~busy && wr_ok && hit_pc)
      program_counter_ff <= PWDATA_I[PC_W-1:0];
  end

  // status word with the global enable
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      cpu_flags_word_ff <= RST_FLAGS;
    else if (accept)
      cpu_flags_word_ff[GIE_BIT] <= 1'b0; // no nesting unless software re-enables [RULE15]
    else if (state_ff == ST_POP && MEM_ACK_I && op_ff == OP_RETI)
      cpu_flags_word_ff[GIE_BIT] <= 1'b1; // return re-enables [RULE17]
    else if (~busy && wr_ok && hit_flags)
      cpu_flags_word_ff <= PWDATA_I;
  end

  // enable register and call target
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      interrupt_enable_reg_ff <= RST_IE[NSRC-1:0];
      target_ff               <= '0;
    end
    else
    begin
      if (wr_ok && hit_ie)
        interrupt_enable_reg_ff <= PWDATA_I[NSRC-1:0];
      if (wr_ok && hit_tgt)
        target_ff <= PWDATA_I[PC_W-1:0];
    end
  end

  // extended precision registers, one writer block per register
  for (genvar r = 0; r < NUM_XP; r++) begin : g_xp
    wire logic pop_here = state_ff == ST_POP && MEM_ACK_I && arg_ff == 3'(r);
    wire logic sw_here  = wr_ok && hit_xp && xp_idx == 3'(r);
    always_ff @(posedge CLK_I)
    begin
      if (RST_I)
        ext_precision_regs_ff[r] <= '0;
      else if (pop_here && op_ff == OP_STACK_LOAD_HIGH)
        ext_precision_regs_ff[r] <= {MEM_RDATA_I, 8'h00}; // low eight bits forced clear [RULE10]
      else if (pop_here && op_ff == OP_POP)
        ext_precision_regs_ff[r][31:0] <= MEM_RDATA_I; // integer low 32 bits only [RULE9]
      else if (sw_here && xp_hi)
        ext_precision_regs_ff[r][XP_W-1:32] <= PWDATA_I[XP_W-33:0];
      else if (sw_here)
        ext_precision_regs_ff[r][31:0] <= PWDATA_I;
    end
  end

  // outputs; address and data come straight from flops
  assign PRDATA_O    = prdata_ff;
  assign MEM_REQ_O   = busy;
  assign MEM_WE_O    = state_ff == ST_PUSH;
  assign MEM_ADDR_O  = mem_addr_ff;
  assign MEM_WDATA_O = mem_wdata_ff;
  assign PC_O        = program_counter_ff;
  assign GIE_O       = global_int_enable;
  assign BUSY_O      = busy;
endmodule : scic_ctrl
`default_nettype wire

// ===== testbench/scic_ctrl_sva.sv
`default_nettype none
module scic_ctrl_sva
  import scic_pkg::*;
#(
  parameter int NSRC = NUM_SRC,
  parameter int AW   = 12
)(
  input wire logic            CLK_I,
  input wire logic            RST_I,
  input wire logic            PSEL_I,
  input wire logic            PENABLE_I,
  input wire logic            PWRITE_I,
  input wire logic [AW-1:0]   PADDR_I,
  input wire logic [31:0]     PWDATA_I,
  input wire logic [31:0]     PRDATA_O,
  input wire logic            PREADY_O,
  input wire logic            PSLVERR_O,
  input wire logic [NSRC-1:0] IRQ_EVT_I,
  input wire logic            MEM_REQ_O,
  input wire logic            MEM_WE_O,
  input wire logic [SP_W-1:0] MEM_ADDR_O,
  input wire logic [31:0]     MEM_WDATA_O,
  input wire logic [31:0]     MEM_RDATA_I,
  input wire logic            MEM_ACK_I,
  input wire logic [PC_W-1:0] PC_O,
  input wire logic            GIE_O,
  input wire logic            BUSY_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // an apb write lands in this cycle; interrupt acceptance is held off then
  logic wr_acc;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;

  a_call_push_next: assert property (
    wr_acc && PADDR_I == OFF_CMD && PWDATA_I[5:0] == 6'h21 && !BUSY_O
    |=> MEM_REQ_O && MEM_WE_O && MEM_WDATA_O[PC_W-1:0] == $past(PC_O) + 24'h1) else $error("call push wrong");
  a_irq_push_pc: assert property (
    !$past(RST_I) && !$past(RST_I, 2) && $rose(MEM_REQ_O) && !$past(wr_acc)
    |-> MEM_WE_O && !GIE_O && MEM_WDATA_O[PC_W-1:0] == PC_O) else $error("accept push wrong");
  a_gie_rise_cause: assert property ($rose(GIE_O) |->
    $past(wr_acc && PADDR_I == OFF_FLAGS && PWDATA_I[GIE_BIT]) || $past(MEM_REQ_O && !MEM_WE_O && MEM_ACK_I))
    else $error("global enable rose alone");
  a_mem_hold: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O)
    && $stable(MEM_WE_O) && $stable(MEM_WDATA_O)) else $error("stack request moved");
  a_sp_locked: assert property (wr_acc && PADDR_I == OFF_SP && BUSY_O |-> PSLVERR_O)
    else $error("stack pointer write not refused");
  a_ready_zero_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O) else $error("ready late");
  a_idle_no_mem: assert property (!BUSY_O |-> !MEM_REQ_O) else $error("stack access while idle");
  a_masked_no_take: assert property (
    !$past(RST_I) && !$past(RST_I, 2) && !GIE_O && !BUSY_O && !wr_acc |=> !MEM_REQ_O)
    else $error("interrupt taken while masked");
endmodule // scic_ctrl_sva

bind scic_ctrl scic_ctrl_sva #(.NSRC(NSRC), .AW(AW)) i_sva (
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .IRQ_EVT_I(IRQ_EVT_I), .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_WDATA_O(MEM_WDATA_O), .MEM_RDATA_I(MEM_RDATA_I), .MEM_ACK_I(MEM_ACK_I), .PC_O(PC_O),
  .GIE_O(GIE_O), .BUSY_O(BUSY_O)
);
`default_nettype wire

// ===== testbench/scic_stack_mem.sv
`default_nettype none
module scic_stack_mem
  import scic_pkg::*;
(
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            req_i,
  input  wire logic            we_i,
  input  wire logic [SP_W-1:0] addr_i,
  input  wire logic [31:0]     wdata_i,
  input  wire logic            slow_i,
  output logic      [31:0]     rdata_o,
  output logic                 ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic [2:0]  wait_cnt;

  // one word per address, low addresses first; slow mode stalls four cycles
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o    <= 1'b0;
      wait_cnt <= 3'h0;
      rdata_o  <= 32'h5A5A_5A5A;
    end
    else if (!req_i || ack_o || wait_cnt != 3'h0)
    begin
      // idle data toggles so a sample outside an ack never looks valid
      ack_o    <= 1'b0;
      rdata_o  <= ~rdata_o;
      wait_cnt <= (!req_i || ack_o) ? (slow_i ? 3'h4 : 3'h0) : wait_cnt - 3'h1;
    end
    else
    begin
      ack_o   <= 1'b1;
      rdata_o <= mem[addr_i[7:0]];
      if (we_i)
        mem[addr_i[7:0]] <= wdata_i;
    end
  end
endmodule // scic_stack_mem
`default_nettype wire

// ===== testbench/stack_call_interrupt_ctrl_tb_top.sv
`default_nettype none
module stack_call_interrupt_ctrl_tb_top
  import scic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk, rst, psel, penable, pwrite, pready, pslverr, slow;
  logic               mem_req, mem_we, mem_ack, global_int_enable, busy, errv;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, mem_rdata, mem_wdata, mem_addr, rdv;
  logic [NUM_SRC-1:0] evt;
  logic [PC_W-1:0]    pc;
  int                 bad_count, n_checks, cyc;

  scic_ctrl i_dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IRQ_EVT_I(evt), .MEM_REQ_O(mem_req), .MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata),
    .MEM_RDATA_I(mem_rdata), .MEM_ACK_I(mem_ack), .PC_O(pc), .GIE_O(global_int_enable), .BUSY_O(busy));
  scic_stack_mem i_mem (.clk_i(clk), .rst_i(rst), .req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr),
    .wdata_i(mem_wdata), .slow_i(slow), .rdata_o(mem_rdata), .ack_o(mem_ack));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a hang ends the run as a mismatch
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("write error", {31'h0, e}, {31'h0, errv});
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdv);
    chk("read error", {31'h0, e}, {31'h0, errv});
  endtask

  task automatic wait_done();
    @(posedge clk);
    while (busy !== 1'b1) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask

  task automatic pulse(input logic [NUM_SRC-1:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= 11'h000;
  endtask

  task automatic t_stack_ptr();
    wait_done();
    chk("reset fetch pc", 32'h0000_0100, {8'h00, pc});
    wr(OFF_SP, 32'h0000_0080, 1'b0);
    rd("sp", OFF_SP, 32'h0000_0080, 1'b0);
    rd("unmapped", 12'h020, 32'h0000_0000, 1'b1);
  endtask

  task automatic t_call_ret();
    slow <= 1'b1;
    wr(OFF_TARGET, 32'h0000_2000, 1'b0);
    wr(OFF_CMD, 32'h0000_0021, 1'b0);
    wr(OFF_SP, 32'h0000_0010, 1'b1);
    wait_done();
    chk("call pc", 32'h0000_2000, {8'h00, pc});
    chk("return addr", 32'h0000_0101, i_mem.mem[8'h81]);
    rd("sp after call", OFF_SP, 32'h0000_0081, 1'b0);
    slow <= 1'b0;
    wr(OFF_CMD, 32'h0000_0002, 1'b0);
    rd("skipped", OFF_CMD, 32'h0000_0002, 1'b0);
    chk("pc kept", 32'h0000_2000, {8'h00, pc});
    wr(OFF_CMD, 32'h0000_0012, 1'b0);
    wait_done();
    chk("ret pc", 32'h0000_0101, {8'h00, pc});
    rd("sp after ret", OFF_SP, 32'h0000_0080, 1'b0);
  endtask

  task automatic t_ext_regs();
    wr(12'h058, 32'h89AB_CDEF, 1'b0);
    wr(12'h05C, 32'h0000_00A5, 1'b0);
    wr(OFF_CMD, 32'h0000_0305, 1'b0);
    wait_done();
    wr(OFF_CMD, 32'h0000_0306, 1'b0);
    wait_done();
    chk("low word", 32'h89AB_CDEF, i_mem.mem[8'h81]);
    chk("high word", 32'hA589_ABCD, i_mem.mem[8'h82]);
    wr(12'h058, 32'h0000_0000, 1'b0);
    wr(12'h05C, 32'h0000_0000, 1'b0);
    wr(OFF_CMD, 32'h0000_0308, 1'b0);
    wait_done();
    rd("high pop low", 12'h058, 32'h89AB_CD00, 1'b0);
    rd("high pop top", 12'h05C, 32'h0000_00A5, 1'b0);
    wr(OFF_CMD, 32'h0000_0307, 1'b0);
    wait_done();
    rd("int pop low", 12'h058, 32'h89AB_CDEF, 1'b0);
    rd("sp after pops", OFF_SP, 32'h0000_0080, 1'b0);
  endtask

  task automatic t_irq();
    wr(OFF_IE, 32'h0000_0000, 1'b0);
    pulse(11'h040);
    rd("flag masked", OFF_IF, 32'h0000_0040, 1'b0);
    wr(OFF_IF, 32'h0000_0000, 1'b0);
    rd("flag cleared", OFF_IF, 32'h0000_0000, 1'b0);
    wr(OFF_IE, 32'h0000_0041, 1'b0);
    pulse(11'h041);
    wr(OFF_FLAGS, 32'h0000_2000, 1'b0);
    wait_done();
    chk("vector zero", 32'h0000_0300, {8'h00, pc});
    chk("gie off", 32'h0, {31'h0, global_int_enable});
    chk("saved pc", 32'h0000_0101, i_mem.mem[8'h81]);
    rd("one left", OFF_IF, 32'h0000_0040, 1'b0);
    wr(OFF_IE, 32'h0000_0001, 1'b0);
    wr(OFF_CMD, 32'h0000_0023, 1'b0);
    wait_done();
    chk("reti pc", 32'h0000_0101, {8'h00, pc});
    chk("gie on", 32'h1, {31'h0, global_int_enable});
    rd("still pending", OFF_IF, 32'h0000_0040, 1'b0);
    wr(OFF_IE, 32'h0000_0040, 1'b0);
    wait_done();
    chk("vector one", 32'h0000_0600, {8'h00, pc});
    wr(OFF_CMD, 32'h0000_0023, 1'b0);
    wait_done();
    wr(OFF_CMD, 32'h0000_0204, 1'b0);
    wait_done();
    chk("trap pc", 32'h0000_0700, {8'h00, pc});
    rd("sp after trap", OFF_SP, 32'h0000_0081, 1'b0);
  endtask

  initial
  begin
    {rst, psel, penable, pwrite, slow} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0;
    evt = 11'h000;
    // vectors: reset, external zero, external one, trap two
    i_mem.mem[0] = 32'h0000_0100;
    i_mem.mem[1] = 32'h0000_0300;
    i_mem.mem[2] = 32'h0000_0600;
    i_mem.mem[8'h22] = 32'h0000_0700;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_stack_ptr();
    t_call_ret();
    t_ext_regs();
    t_irq();
    tally_and_finish();
  end
endmodule // stack_call_interrupt_ctrl_tb_top
`default_nettype wire
